// ---- rtl/ammr_fc_timer.sv ----
`timescale 1ns/100ps
`default_nettype none
module ammr_fc_timer import ammr_pkg::*; #(
	parameter int N_WIDTH = 10
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [N_WIDTH-1:0] n_steps,
	input wire logic start,
	output logic window_open
);
	ammr_fc_state_t state_reg;
	logic [AMMR_FC_ACC_W-1:0] acc_reg;
	logic [AMMR_FC_ACC_W-1:0] target;
	logic [AMMR_FC_ACC_W-1:0] acc_next;
	logic [15:0] len_reg;

	if (N_WIDTH > 10) begin : g_chk
		$error("Fast-clear step count wider than the accumulator serves.");
	end

	// Window closes on the last whole cycle within 7 us plus N steps.
	assign target = AMMR_FC_ACC_W'(AMMR_FC_BASE_U)
		+ AMMR_FC_ACC_W'(n_steps * AMMR_FC_STEP_U);
	assign acc_next = acc_reg + AMMR_FC_ACC_W'(AMMR_CLK_U);
	assign window_open = (state_reg == AMMR_FC_OPEN);

	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg <= AMMR_FC_IDLE;
			acc_reg <= '0;
		end else begin
			case (state_reg)
				AMMR_FC_IDLE: begin
					if (start) begin
						state_reg <= AMMR_FC_OPEN;
						acc_reg <= AMMR_FC_ACC_W'(AMMR_CLK_U);
					end
				end
				AMMR_FC_OPEN: begin
					if (acc_next > target) begin
						state_reg <= AMMR_FC_IDLE;
					end
					acc_reg <= acc_next;
				end
				default: state_reg <= AMMR_FC_IDLE;
			endcase
		end
	end

	// Helper count of open cycles, read only by the checks below.
	always_ff @(posedge clk) begin
		if (reset || !window_open) begin
			len_reg <= 16'h0001;
		end else begin
			len_reg <= len_reg + 16'h0001;
		end
	end

	a_fc_window_len: assert property (@(posedge clk) disable iff (reset)
		window_open && $stable(n_steps)
		|-> 32'(len_reg) <= 32'(target) / AMMR_CLK_U)
		else $error("Fast-clear window stays open too long.");
	a_fc_close_time: assert property (@(posedge clk) disable iff (reset)
		$fell(window_open) && $stable(n_steps) |->
		32'($past(len_reg)) == 32'($past(target)) / AMMR_CLK_U)
		else $error("Fast-clear window has wrong length.");
	a_fc_start_open: assert property (@(posedge clk) disable iff (reset)
		!window_open && start |=> window_open)
		else $error("Fast-clear window did not open after start.");
endmodule
`default_nettype wire

// ---- rtl/ammr_pkg.sv ----
package ammr_pkg;
	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [15:0] AMMR_OFS_EVENT_ADV = 16'h1028;
	localparam logic [15:0] AMMR_OFS_WORD_ADV = 16'h102a;
	localparam logic [15:0] AMMR_OFS_FC_WINDOW = 16'h102e;
	localparam logic [15:0] AMMR_OFS_MODE_SET = 16'h1032;
	localparam logic [15:0] AMMR_OFS_MODE_CLR = 16'h1034;
	localparam logic [15:0] AMMR_OFS_MT_WADDR = 16'h1036;
	localparam logic [15:0] AMMR_OFS_MT_UPPER = 16'h1038;
	localparam logic [15:0] AMMR_OFS_MT_LOWER = 16'h103a;

	// ****************************************************************
	// Mode bit positions, implemented mask and reset value
	// ****************************************************************
	localparam int AMMR_B_MEMTEST = 0;
	localparam int AMMR_B_OFFLINE = 1;
	localparam int AMMR_B_DATA_WIPE = 2;
	localparam int AMMR_B_OVF_OFF = 3;
	localparam int AMMR_B_ZS_OFF = 4;
	localparam int AMMR_B_ACQ_TEST = 6;
	localparam int AMMR_B_SLIDE_EN = 7;
	localparam int AMMR_B_TH_RES = 8;
	localparam int AMMR_B_AUTO_ADV = 11;
	localparam int AMMR_B_EMPTY_WR = 12;
	localparam int AMMR_B_SUB_OFF = 13;
	localparam int AMMR_B_ALL_TRIGGER_COUNT = 14;
	localparam logic [15:0] AMMR_MODE_MASK = 16'h79df;
	localparam logic [15:0] AMMR_MODE_RESET = 16'h4880;

	// ****************************************************************
	// Fast-clear timing, in units of 1/32 ns
	// ****************************************************************
	localparam int AMMR_SUB_PER_NS = 32;
	localparam int AMMR_CLK_PERIOD_NS = 50;
	localparam int AMMR_FC_BASE_NS = 7000;
	localparam int AMMR_FC_STEPS_PER_US = 32;
	localparam int AMMR_FC_BASE_U = AMMR_FC_BASE_NS * AMMR_SUB_PER_NS;
	localparam int AMMR_FC_STEP_U = 1000 * AMMR_SUB_PER_NS
		/ AMMR_FC_STEPS_PER_US;
	localparam int AMMR_CLK_U = AMMR_CLK_PERIOD_NS * AMMR_SUB_PER_NS;
	localparam int AMMR_FC_ACC_W = 21;
	localparam logic [9:0] AMMR_FC_N_MAX = 10'h3f0;

	// ****************************************************************
	// Threshold scaling
	// ****************************************************************
	localparam int AMMR_TH_SHIFT_COARSE = 4;
	localparam int AMMR_TH_SHIFT_FINE = 1;

	typedef enum logic [1:0] {
		AMMR_FC_IDLE = 2'b00,
		AMMR_FC_OPEN = 2'b01
	} ammr_fc_state_t;
endpackage

// ---- rtl/ammr_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
module ammr_regs import ammr_pkg::*; #(
	parameter int FC_N_WIDTH = 10,
	parameter int MEM_ADDR_WIDTH = 11
) (
	input wire logic SYS_CLK,
	input wire logic RESET,
	input wire logic [15:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [15:0] REG_RDATA,
	output logic REG_ACK,
	output logic MEMTEST_MODE,
	output logic CONV_OFFLINE,
	output logic DATA_RESET,
	output logic OVERFLOW_CHECK_OFF,
	output logic ZERO_SUPPRESS_OFF,
	output logic ACQUISITION_TEST_SELECT,
	output logic SLIDE_ENABLE,
	output logic THRESHOLD_RESOLUTION,
	output logic POINTER_AUTO_ADVANCE,
	output logic EMPTY_EVENT_WRITE,
	output logic SLIDE_SUB_BYPASS,
	output logic ALL_TRIGGER_COUNT,
	output logic [FC_N_WIDTH-1:0] FAST_CLEAR_WINDOW_WIDTH,
	input wire logic FC_START,
	output logic FC_WINDOW_OPEN,
	output logic MEM_WR,
	output logic [MEM_ADDR_WIDTH-1:0] MEM_ADDR,
	output logic [31:0] MEM_DATA,
	input wire logic BUF_READ,
	output logic PTR_WORD_ADVANCE,
	output logic PTR_EVENT_ADVANCE,
	input wire logic CH_VALID,
	input wire logic [11:0] CH_VALUE,
	input wire logic CH_OVERFLOW,
	input wire logic [7:0] CH_THRESHOLD,
	output logic CH_STORE,
	input wire logic EVENT_END,
	input wire logic EVENT_ACCEPTED_ANY,
	output logic EVENT_WRITE_FRAME,
	input wire logic TRIGGER,
	input wire logic TRIGGER_ACCEPTED,
	output logic EVENT_COUNT_INC
);
	// ****************************************************************
	// Declarations and parameter checks
	// ****************************************************************
	logic [15:0] mode_reg;
	logic [15:0] mode_next;
	logic [FC_N_WIDTH-1:0] fcw_reg;
	logic [MEM_ADDR_WIDTH-1:0] mt_addr_reg;
	logic [15:0] mt_upper_reg;
	logic mem_wr_reg;
	logic [31:0] mem_data_reg;
	logic [15:0] rdata_reg;
	logic ack_reg;
	logic word_adv_reg;
	logic event_adv_reg;
	logic store_reg;
	logic frame_reg;
	logic count_reg;
	logic wr_set;
	logic wr_clr;
	logic wr_fcw;
	logic wr_addr;
	logic wr_upper;
	logic wr_lower;
	logic wr_word_adv;
	logic wr_event_adv;

	if (FC_N_WIDTH != 10) begin : g_chk_fc
		$error("Fast-clear field must be 10 bits wide.");
	end
	if (MEM_ADDR_WIDTH < 1 || MEM_ADDR_WIDTH > 16) begin : g_chk_addr
		$error("Memory test address must fit a 16-bit register.");
	end

	// Decodes an address match for one register offset.
	function automatic logic hit(input logic [15:0] addr,
			input logic [15:0] ofs);
		hit = (addr == ofs);
	endfunction

	// True when the value falls below the scaled threshold.
	function automatic logic below_threshold(input logic [11:0] value,
			input logic [7:0] thr, input logic fine);
		logic [12:0] limit;
		limit = '0;
		if (fine) begin
			limit = 13'(thr) << AMMR_TH_SHIFT_FINE;
		end else begin
			limit = 13'(thr) << AMMR_TH_SHIFT_COARSE;
		end
		below_threshold = (13'(value) < limit);
	endfunction

	assign wr_set = REG_WR && hit(REG_ADDR, AMMR_OFS_MODE_SET);
	assign wr_clr = REG_WR && hit(REG_ADDR, AMMR_OFS_MODE_CLR);
	assign wr_fcw = REG_WR && hit(REG_ADDR, AMMR_OFS_FC_WINDOW);
	assign wr_addr = REG_WR && hit(REG_ADDR, AMMR_OFS_MT_WADDR);
	assign wr_upper = REG_WR && hit(REG_ADDR, AMMR_OFS_MT_UPPER);
	assign wr_lower = REG_WR && hit(REG_ADDR, AMMR_OFS_MT_LOWER);
	assign wr_word_adv = REG_WR && hit(REG_ADDR, AMMR_OFS_WORD_ADV);
	assign wr_event_adv = REG_WR && hit(REG_ADDR, AMMR_OFS_EVENT_ADV);

	// ****************************************************************
	// Operating-mode register
	// ****************************************************************
	always_comb begin
		mode_next = mode_reg;
		if (wr_set) begin
			mode_next = mode_reg | (REG_WDATA & AMMR_MODE_MASK);
		end else if (wr_clr) begin
			mode_next = mode_reg & ~(REG_WDATA & AMMR_MODE_MASK);
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			mode_reg <= AMMR_MODE_RESET;
		end else begin
			mode_reg <= mode_next;
		end
	end

	assign MEMTEST_MODE = mode_reg[AMMR_B_MEMTEST];
	assign CONV_OFFLINE = mode_reg[AMMR_B_OFFLINE];
	assign DATA_RESET = mode_reg[AMMR_B_DATA_WIPE];
	assign OVERFLOW_CHECK_OFF = mode_reg[AMMR_B_OVF_OFF];
	assign ZERO_SUPPRESS_OFF = mode_reg[AMMR_B_ZS_OFF];
	assign ACQUISITION_TEST_SELECT = mode_reg[AMMR_B_ACQ_TEST];
	assign SLIDE_ENABLE = mode_reg[AMMR_B_SLIDE_EN];
	assign THRESHOLD_RESOLUTION = mode_reg[AMMR_B_TH_RES];
	assign POINTER_AUTO_ADVANCE = mode_reg[AMMR_B_AUTO_ADV];
	assign EMPTY_EVENT_WRITE = mode_reg[AMMR_B_EMPTY_WR];
	assign SLIDE_SUB_BYPASS = mode_reg[AMMR_B_SUB_OFF];
	assign ALL_TRIGGER_COUNT = mode_reg[AMMR_B_ALL_TRIGGER_COUNT];

	// ****************************************************************
	// Fast-clear window
	// ****************************************************************
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			fcw_reg <= '0;
		end else if (wr_fcw) begin
			fcw_reg <= REG_WDATA[FC_N_WIDTH-1:0];
		end
	end

	assign FAST_CLEAR_WINDOW_WIDTH = fcw_reg;

	ammr_fc_timer #(
		.N_WIDTH(FC_N_WIDTH)
	) u_fc_timer (
		.clk(SYS_CLK),
		.reset(RESET),
		.n_steps(fcw_reg),
		.start(FC_START),
		.window_open(FC_WINDOW_OPEN)
	);

	// ****************************************************************
	// Memory test write side
	// ****************************************************************
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			mt_addr_reg <= '0;
		end else if (wr_addr) begin
			mt_addr_reg <= REG_WDATA[MEM_ADDR_WIDTH-1:0];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			mt_upper_reg <= '0;
		end else if (wr_upper) begin
			mt_upper_reg <= REG_WDATA;
		end
	end

	// The lower-half write completes the word; in memory test mode MEM_WR stores it on the next cycle.
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			mem_wr_reg <= 1'b0;
			mem_data_reg <= '0;
		end else begin
			mem_wr_reg <= wr_lower && MEMTEST_MODE;
			if (wr_lower) begin
				mem_data_reg <= {mt_upper_reg, REG_WDATA};
			end
		end
	end

	assign MEM_WR = mem_wr_reg;
	assign MEM_ADDR = mt_addr_reg;
	assign MEM_DATA = mem_data_reg;

	// ****************************************************************
	// Readout pointer advance
	// ****************************************************************
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			word_adv_reg <= 1'b0;
			event_adv_reg <= 1'b0;
		end else begin
			word_adv_reg <= wr_word_adv
				|| (POINTER_AUTO_ADVANCE && BUF_READ);
			event_adv_reg <= wr_event_adv;
		end
	end

	assign PTR_WORD_ADVANCE = word_adv_reg;
	assign PTR_EVENT_ADVANCE = event_adv_reg;

	// ****************************************************************
	// Channel acceptance, empty events and event counting
	// ****************************************************************
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			store_reg <= 1'b0;
		end else begin
			store_reg <= CH_VALID && !CONV_OFFLINE
				&& (OVERFLOW_CHECK_OFF || !CH_OVERFLOW)
				&& (ZERO_SUPPRESS_OFF || !below_threshold(CH_VALUE,
				CH_THRESHOLD, THRESHOLD_RESOLUTION));
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			frame_reg <= 1'b0;
		end else begin
			frame_reg <= EVENT_END
				&& (EVENT_ACCEPTED_ANY || EMPTY_EVENT_WRITE);
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			count_reg <= 1'b0;
		end else begin
			count_reg <= TRIGGER
				&& (ALL_TRIGGER_COUNT || TRIGGER_ACCEPTED);
		end
	end

	assign CH_STORE = store_reg;
	assign EVENT_WRITE_FRAME = frame_reg;
	assign EVENT_COUNT_INC = count_reg;

	// ****************************************************************
	// Register read port
	// ****************************************************************
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			rdata_reg <= '0;
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= REG_WR || REG_RD;
			rdata_reg <= '0;
			if (REG_RD) begin
				if (hit(REG_ADDR, AMMR_OFS_MODE_SET)) begin
					rdata_reg <= mode_reg;
				end else if (hit(REG_ADDR, AMMR_OFS_FC_WINDOW)) begin
					rdata_reg <= 16'(fcw_reg);
				end
			end
		end
	end

	assign REG_RDATA = rdata_reg;
	assign REG_ACK = ack_reg;

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_mode_set_ones: assert property (@(posedge SYS_CLK) disable iff (RESET)
		wr_set |=> mode_reg == ($past(mode_reg)
		| ($past(REG_WDATA) & AMMR_MODE_MASK)))
		else $error("Mode set write lost or altered bits.");
	a_mode_clr_bits: assert property (@(posedge SYS_CLK) disable iff (RESET)
		wr_clr |=> mode_reg == ($past(mode_reg)
		& ~($past(REG_WDATA) & AMMR_MODE_MASK)))
		else $error("Mode clear write gave wrong bits.");
	a_mode_read_back: assert property (@(posedge SYS_CLK) disable iff (RESET)
		REG_RD && hit(REG_ADDR, AMMR_OFS_MODE_SET) && !REG_WR
		|=> REG_ACK && REG_RDATA == $past(mode_reg))
		else $error("Mode read returned wrong value.");
	a_data_wipe_level: assert property (@(posedge SYS_CLK)
		disable iff (RESET)
		wr_set && REG_WDATA[AMMR_B_DATA_WIPE] |=> DATA_RESET)
		else $error("Data reset not raised by wipe bit.");
	a_mode_defaults: assert property (@(posedge SYS_CLK)
		$past(RESET) |-> mode_reg == AMMR_MODE_RESET)
		else $error("Mode bits not at defaults after reset.");
	a_memtest_store: assert property (@(posedge SYS_CLK) disable iff (RESET)
		wr_lower && MEMTEST_MODE |=> MEM_WR
		&& MEM_DATA == {$past(mt_upper_reg), $past(REG_WDATA)})
		else $error("Memory test word not stored.");
	a_memtest_gate: assert property (@(posedge SYS_CLK) disable iff (RESET)
		MEM_WR |-> $past(MEMTEST_MODE) && $past(wr_lower))
		else $error("Memory written outside test mode.");
	a_ptr_manual: assert property (@(posedge SYS_CLK) disable iff (RESET)
		BUF_READ && !POINTER_AUTO_ADVANCE && !wr_word_adv
		|=> !PTR_WORD_ADVANCE)
		else $error("Pointer advanced while auto advance is off.");
	a_ptr_word_adv: assert property (@(posedge SYS_CLK) disable iff (RESET)
		wr_word_adv |=> PTR_WORD_ADVANCE)
		else $error("Word-advance write did not move pointer.");
	a_count_mode: assert property (@(posedge SYS_CLK) disable iff (RESET)
		TRIGGER ##0 (ALL_TRIGGER_COUNT || TRIGGER_ACCEPTED)
		|=> EVENT_COUNT_INC)
		else $error("Event counter increment missing.");
	a_empty_frame: assert property (@(posedge SYS_CLK) disable iff (RESET)
		EVENT_END && !EVENT_ACCEPTED_ANY && !EMPTY_EVENT_WRITE
		|=> !EVENT_WRITE_FRAME)
		else $error("Frame written for an empty event.");
	a_ovf_suppress: assert property (@(posedge SYS_CLK) disable iff (RESET)
		CH_VALID && CH_OVERFLOW && !OVERFLOW_CHECK_OFF |=> !CH_STORE)
		else $error("Overflowed data stored.");
	a_zero_suppress: assert property (@(posedge SYS_CLK)
		disable iff (RESET)
		CH_VALID && !ZERO_SUPPRESS_OFF && !THRESHOLD_RESOLUTION
		&& ({1'b0, CH_VALUE}
		< ({5'h00, CH_THRESHOLD} << AMMR_TH_SHIFT_COARSE))
		|=> !CH_STORE)
		else $error("Below-threshold data stored.");
	a_offline_halt: assert property (@(posedge SYS_CLK) disable iff (RESET)
		CONV_OFFLINE |=> !CH_STORE)
		else $error("Data stored while converter offline.");
endmodule
`default_nettype wire

// ---- tb/ammr_regs_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module ammr_regs_bench import ammr_pkg::*;;
	logic sys_clk, reset, reg_wr, reg_rd, reg_ack;
	logic [15:0] reg_addr, reg_wdata, reg_rdata, v;
	logic memtest, conv_off, data_reset, ovf_off, zs_off, acq_test;
	logic slide_en, th_res, auto_adv, empty_wr, sub_byp, all_trigger_count;
	logic [9:0] fc_n;
	logic fc_start, fc_open, mem_wr, buf_read, ptr_word, ptr_event;
	logic [10:0] mem_addr;
	logic [31:0] mem_data;
	logic ch_valid, ch_overflow, ch_store, event_end, event_acc, frame;
	logic [11:0] ch_value;
	logic [7:0] ch_threshold;
	logic trigger, trigger_acc, cnt_inc, mw_seen, pw_seen, pe_seen;
	logic [15:0] exp_mode;
	wire logic [15:0] mode_out;
	int miscompares, compares;

	assign mode_out = {1'b0, all_trigger_count, sub_byp, empty_wr, auto_adv, 2'b00,
		th_res, slide_en, acq_test, 1'b0, zs_off, ovf_off, data_reset,
		conv_off, memtest};

	ammr_regs dut (.SYS_CLK(sys_clk), .RESET(reset), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
		.REG_RDATA(reg_rdata), .REG_ACK(reg_ack), .MEMTEST_MODE(memtest),
		.CONV_OFFLINE(conv_off), .DATA_RESET(data_reset),
		.OVERFLOW_CHECK_OFF(ovf_off), .ZERO_SUPPRESS_OFF(zs_off),
		.ACQUISITION_TEST_SELECT(acq_test), .SLIDE_ENABLE(slide_en),
		.THRESHOLD_RESOLUTION(th_res), .POINTER_AUTO_ADVANCE(auto_adv),
		.EMPTY_EVENT_WRITE(empty_wr), .SLIDE_SUB_BYPASS(sub_byp),
		.ALL_TRIGGER_COUNT(all_trigger_count), .FAST_CLEAR_WINDOW_WIDTH(fc_n),
		.FC_START(fc_start), .FC_WINDOW_OPEN(fc_open), .MEM_WR(mem_wr),
		.MEM_ADDR(mem_addr), .MEM_DATA(mem_data), .BUF_READ(buf_read),
		.PTR_WORD_ADVANCE(ptr_word), .PTR_EVENT_ADVANCE(ptr_event),
		.CH_VALID(ch_valid), .CH_VALUE(ch_value),
		.CH_OVERFLOW(ch_overflow), .CH_THRESHOLD(ch_threshold),
		.CH_STORE(ch_store), .EVENT_END(event_end),
		.EVENT_ACCEPTED_ANY(event_acc), .EVENT_WRITE_FRAME(frame),
		.TRIGGER(trigger), .TRIGGER_ACCEPTED(trigger_acc),
		.EVENT_COUNT_INC(cnt_inc));

	// ****************************************************************
	// Clock, checking and closing
	// ****************************************************************
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		repeat (100000) @(posedge sys_clk);
		miscompares++;
		report_and_stop();
	end

	// ****************************************************************
	// Access tasks
	// ****************************************************************
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge sys_clk);
		reg_wr = 1'b0;
		mw_seen = mem_wr;
		pw_seen = ptr_word;
		pe_seen = ptr_event;
		check(reg_ack, 1'b1);
	endtask

	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge sys_clk);
		reg_rd = 1'b0;
		d = reg_rdata;
		check(reg_ack, 1'b1);
	endtask

	task automatic fc_run(input logic [15:0] n);
		int cnt;
		int exp;
		exp = (7000 * 32 + int'(n) * 1000) / (50 * 32);
		wr(AMMR_OFS_FC_WINDOW, n);
		check(fc_n, n[9:0]);
		@(negedge sys_clk);
		fc_start = 1'b1;
		@(negedge sys_clk);
		fc_start = 1'b0;
		cnt = 0;
		while (fc_open === 1'b1 && cnt < 1000) begin
			cnt++;
			fc_start = (cnt == 10);
			@(negedge sys_clk);
		end
		check(cnt, exp);
		if (cnt >= 1000) begin
			report_and_stop();
		end
	endtask

	task automatic chan(input logic [11:0] val, input logic [7:0] thr,
		input logic ovf, input logic exp);
		@(negedge sys_clk);
		ch_value = val;
		ch_threshold = thr;
		ch_overflow = ovf;
		ch_valid = 1'b1;
		@(negedge sys_clk);
		ch_valid = 1'b0;
		check(ch_store, exp);
	endtask

	task automatic evt(input logic acc, input logic ef, input logic ei);
		@(negedge sys_clk);
		event_end = 1'b1;
		trigger = 1'b1;
		event_acc = acc;
		trigger_acc = acc;
		@(negedge sys_clk);
		event_end = 1'b0;
		trigger = 1'b0;
		check(frame, ef);
		check(cnt_inc, ei);
	endtask

	task automatic brd(input logic exp);
		@(negedge sys_clk);
		buf_read = 1'b1;
		@(negedge sys_clk);
		buf_read = 1'b0;
		check(ptr_word, exp);
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		miscompares = 0;
		compares = 0;
		reset = 1'b1;
		{reg_wr, reg_rd, fc_start, buf_read, ch_valid, ch_overflow} = '0;
		{event_end, event_acc, trigger, trigger_acc} = '0;
		reg_addr = 16'h0000;
		reg_wdata = 16'h0000;
		ch_value = 12'h000;
		ch_threshold = 8'h00;
		repeat (2) @(negedge sys_clk);
		reset = 1'b0;
		check(mode_out, 16'h4880);
		rd(AMMR_OFS_MODE_SET, v);
		check(v, 16'h4880);
		rd(AMMR_OFS_FC_WINDOW, v);
		check(v, 16'h0000);
		exp_mode = 16'h4880;
		for (int i = 0; i < 16; i++) begin
			wr(AMMR_OFS_MODE_SET, 16'h0001 << i);
			exp_mode[i] = exp_mode[i] | AMMR_MODE_MASK[i];
			check(mode_out, exp_mode);
			rd(AMMR_OFS_MODE_SET, v);
			check(v, exp_mode);
		end
		wr(AMMR_OFS_MODE_SET, 16'h0000);
		check(mode_out, exp_mode);
		for (int i = 0; i < 16; i++) begin
			wr(AMMR_OFS_MODE_CLR, 16'h0001 << i);
			exp_mode[i] = 1'b0;
			check(mode_out, exp_mode);
		end
		wr(AMMR_OFS_MODE_SET, 16'h0004);
		check(data_reset, 1'b1);
		wr(AMMR_OFS_MODE_CLR, 16'h0000);
		check(data_reset, 1'b1);
		wr(AMMR_OFS_MODE_CLR, 16'h0004);
		check(data_reset, 1'b0);
		wr(AMMR_OFS_MODE_SET, 16'h4880);
		wr(AMMR_OFS_FC_WINDOW, 16'hfff0);
		rd(AMMR_OFS_FC_WINDOW, v);
		check(v, 16'h03f0);
		fc_run(16'h0000);
		fc_run(16'h0020);
		fc_run(16'h03f0);
		rd(AMMR_OFS_FC_WINDOW, v);
		check(v, 16'h03f0);
		wr(AMMR_OFS_MODE_SET, 16'h0001);
		check(memtest, 1'b1);
		wr(AMMR_OFS_MT_WADDR, 16'h0005);
		check(mem_addr, 11'h005);
		wr(AMMR_OFS_MT_UPPER, 16'habcd);
		check(mw_seen, 1'b0);
		wr(AMMR_OFS_MT_LOWER, 16'h1234);
		check(mw_seen, 1'b1);
		check(mem_data, 32'habcd1234);
		check(mem_addr, 11'h005);
		@(negedge sys_clk);
		check(mem_wr, 1'b0);
		wr(AMMR_OFS_MT_WADDR, 16'h07ff);
		wr(AMMR_OFS_MT_UPPER, 16'hffff);
		wr(AMMR_OFS_MT_LOWER, 16'h0000);
		check(mw_seen, 1'b1);
		check(mem_addr, 11'h7ff);
		check(mem_data, 32'hffff0000);
		rd(AMMR_OFS_MT_WADDR, v);
		check(v, 16'h0000);
		wr(AMMR_OFS_MODE_CLR, 16'h0001);
		wr(AMMR_OFS_MT_LOWER, 16'h5555);
		check(mw_seen, 1'b0);
		rd(16'h2000, v);
		check(v, 16'h0000);
		wr(AMMR_OFS_WORD_ADV, 16'h0000);
		check({pw_seen, pe_seen}, 2'b10);
		wr(AMMR_OFS_EVENT_ADV, 16'h0000);
		check({pw_seen, pe_seen}, 2'b01);
		brd(1'b1);
		wr(AMMR_OFS_MODE_CLR, 16'h0800);
		brd(1'b0);
		wr(AMMR_OFS_MODE_SET, 16'h0800);
		chan(12'h100, 8'h10, 1'b0, 1'b1);
		chan(12'h0ff, 8'h10, 1'b0, 1'b0);
		chan(12'h100, 8'h10, 1'b1, 1'b0);
		wr(AMMR_OFS_MODE_SET, 16'h0008);
		chan(12'h100, 8'h10, 1'b1, 1'b1);
		wr(AMMR_OFS_MODE_SET, 16'h0100);
		chan(12'h020, 8'h10, 1'b0, 1'b1);
		chan(12'h01f, 8'h10, 1'b0, 1'b0);
		wr(AMMR_OFS_MODE_SET, 16'h0010);
		chan(12'h01f, 8'h10, 1'b0, 1'b1);
		wr(AMMR_OFS_MODE_SET, 16'h0002);
		chan(12'h100, 8'h10, 1'b0, 1'b0);
		wr(AMMR_OFS_MODE_CLR, 16'h011a);
		evt(1'b0, 1'b0, 1'b1);
		evt(1'b1, 1'b1, 1'b1);
		wr(AMMR_OFS_MODE_SET, 16'h1000);
		wr(AMMR_OFS_MODE_CLR, 16'h4000);
		evt(1'b0, 1'b1, 1'b0);
		evt(1'b1, 1'b1, 1'b1);
		@(negedge sys_clk);
		reset = 1'b1;
		@(negedge sys_clk);
		reset = 1'b0;
		check(mode_out, 16'h4880);
		check(fc_n, 10'h000);
		check(mem_addr, 11'h000);
		check(mem_data, 32'h00000000);
		rd(AMMR_OFS_MODE_SET, v);
		check(v, 16'h4880);
		report_and_stop();
	end
endmodule
`default_nettype wire
